// ==== inc/fcss_pkg.sv ====
// Purpose: Constants and types for the flash command/status host sequencer.
// Assumes: 100 MHz i_mclk; 16-bit data pins, command codes on the low byte.
// Notes: Bus timing figures are conservative defaults for an asynchronous part.

package fcss_pkg;

	localparam int ADDR_W = 20;
	localparam int DQ_W = 16;
	localparam int CLK_MHZ = 100;

	// Bus timing in nanoseconds, converted to whole cycles rounding up
	localparam int T_WE_LOW_NS = 50;
	localparam int T_WE_HIGH_NS = 30;
	localparam int T_ACCESS_NS = 100;
	localparam int T_READ_GAP_NS = 30;
	localparam logic [7:0] WE_LOW_CYC = 8'((T_WE_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] WE_HIGH_CYC = 8'((T_WE_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] ACCESS_CYC = 8'((T_ACCESS_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] READ_GAP_CYC = 8'((T_READ_GAP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] SYNC_SETTLE_CYC = 8'h03;

	// Command codes
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CHIP_SETUP = 8'h30;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
	localparam logic [7:0] CMD_LOCK_PERM = 8'hF1;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;

	// Field positions of operation_status
	localparam int SR_READY_BIT = 7;
	localparam int SR_ERASE_SUSP_BIT = 6;
	localparam int SR_ERASE_ERR_BIT = 5;
	localparam int SR_PROG_ERR_BIT = 4;
	localparam int SR_SUPPLY_BIT = 3;
	localparam int SR_PROG_SUSP_BIT = 2;
	localparam int SR_PROTECT_BIT = 1;
	localparam logic [7:0] SR_POLL_MASK = 8'hFE;
	localparam logic [7:0] SR_ERROR_MASK = 8'h3A;

	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [DQ_W-1:0] DQ_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;

	typedef enum logic [3:0] {
		OP_BLOCK_ERASE,
		OP_CHIP_ERASE,
		OP_LOCK_BLOCK,
		OP_LOCK_PERM,
		OP_SUSPEND,
		OP_RESUME,
		OP_READ_STATUS,
		OP_CLEAR_STATUS,
		OP_READ_ARRAY
	} fcss_op_t;

	typedef enum logic [1:0] {
		END_NONE,
		END_POLL,
		END_READ
	} fcss_end_t;

endpackage : fcss_pkg

// ==== rtl/fcss_sync.sv ====
// Purpose: Three-stage synchroniser for asynchronous pin inputs.
// Assumes: Inputs change slowly relative to i_mclk.
// Notes: o_stable flags when stages two and three agree; the ready-pin instance leaves it unused.
`timescale 1ns/1ps
`default_nettype none

module fcss_sync #(
	parameter int W = 1
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_value,
	output logic o_stable
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// Stage one is read only by stage two
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			meta_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end
		else
		begin
			meta_reg <= i_async;
			s2_reg <= meta_reg;
			s3_reg <= s2_reg;
		end
	end

	assign o_value = s3_reg;
	assign o_stable = (s2_reg == s3_reg);

endmodule : fcss_sync

`default_nettype wire

// ==== rtl/fcss_host.sv ====
// Purpose: Host sequencer driving a parallel flash's command/status interface.
// Assumes: One request at a time; device pins are asynchronous to i_mclk.
// Notes: Erase and lock requests are refused while an error is pending.
`timescale 1ns/1ps
`default_nettype none

module fcss_host
	import fcss_pkg::*;
#(
	parameter logic [7:0] P_CLEAR_STATUS_CODE = 8'h50
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic [3:0] i_op,
	input wire logic [ADDR_W-1:0] i_addr,
	output logic o_req_ready,
	output logic o_done,
	output logic o_refused,
	output logic [7:0] o_status,
	output logic [DQ_W-1:0] o_rdata,
	output logic o_error_pending,
	output logic o_device_ready,
	output logic o_reset_powerdown_n,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [ADDR_W-1:0] o_addr,
	input wire logic [DQ_W-1:0] i_dq,
	output logic [DQ_W-1:0] o_dq,
	output logic o_dq_oe_n,
	input wire logic i_ready_busy_n
);

	typedef enum logic [2:0] {
		S_IDLE, S_SETUP, S_WE_LOW, S_WE_HIGH, S_RD_ACCESS, S_RD_SAMPLE, S_RD_GAP, S_DONE
	} fcss_state_t;

	fcss_state_t state_reg, state_next;
	fcss_op_t op_reg, op_next;
	logic [7:0] cnt_reg, cnt_next;
	logic step_reg, step_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DQ_W-1:0] dq_reg, dq_next;
	logic dq_oe_n_reg, dq_oe_n_next;
	logic ce_n_reg, ce_n_next;
	logic we_n_reg, we_n_next;
	logic oe_n_reg, oe_n_next;
	logic [7:0] status_reg, status_next;
	logic [DQ_W-1:0] rdata_reg, rdata_next;
	logic done_reg, done_next;
	logic refused_reg, refused_next;
	logic err_pend_reg, err_pend_next;
	logic rp_n_reg;
	logic [DQ_W-1:0] dq_sync;
	logic dq_stable;
	logic [0:0] rb_sync;

	// Pin inputs cross from the device's asynchronous timing
	fcss_sync #(.W(DQ_W)) u_dq_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_async(i_dq),
		.o_value(dq_sync),
		.o_stable(dq_stable)
	);

	fcss_sync #(.W(1)) u_rb_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_async(i_ready_busy_n),
		.o_value(rb_sync),
		.o_stable()
	);

	// Request decode
	wire req_op_legal = (i_op <= 4'(OP_READ_ARRAY));
	wire req_needs_clean = (i_op == 4'(OP_BLOCK_ERASE)) || (i_op == 4'(OP_CHIP_ERASE)) ||
		(i_op == 4'(OP_LOCK_BLOCK)) || (i_op == 4'(OP_LOCK_PERM));
	wire req_refuse = !req_op_legal || (req_needs_clean && err_pend_reg);

	// Per-operation command codes; two-cycle sequences pair setup with confirm
	wire [7:0] first_code =
		(op_reg == OP_BLOCK_ERASE) ? CMD_ERASE_SETUP :
		(op_reg == OP_CHIP_ERASE) ? CMD_CHIP_SETUP :
		(op_reg == OP_LOCK_BLOCK) ? CMD_LOCK_SETUP :
		(op_reg == OP_LOCK_PERM) ? CMD_LOCK_SETUP :
		(op_reg == OP_SUSPEND) ? CMD_SUSPEND :
		(op_reg == OP_RESUME) ? CMD_CONFIRM :
		(op_reg == OP_READ_STATUS) ? CMD_READ_STATUS :
		(op_reg == OP_CLEAR_STATUS) ? P_CLEAR_STATUS_CODE :
		CMD_READ_ARRAY;
	wire [7:0] second_code =
		(op_reg == OP_LOCK_BLOCK) ? CMD_LOCK_BLOCK :
		(op_reg == OP_LOCK_PERM) ? CMD_LOCK_PERM :
		CMD_CONFIRM;
	wire has_second = (op_reg == OP_BLOCK_ERASE) || (op_reg == OP_CHIP_ERASE) ||
		(op_reg == OP_LOCK_BLOCK) || (op_reg == OP_LOCK_PERM);
	wire fcss_end_t end_kind =
		(has_second || op_reg == OP_SUSPEND) ? END_POLL :
		(op_reg == OP_READ_STATUS || op_reg == OP_READ_ARRAY) ? END_READ :
		END_NONE;
	// Reserved bit 0 never reaches o_status
	wire [7:0] sampled_status = dq_sync[7:0] & SR_POLL_MASK;
	wire poll_again = (end_kind == END_POLL) && !sampled_status[SR_READY_BIT];
	// Status reads also count toward the pending error, so chained erases
	// are refused after the first one whose poll shows an error
	wire status_read = (end_kind == END_POLL) || (op_reg == OP_READ_STATUS);

	// Sequencer next-state
	always_comb
	begin
		state_next = state_reg;
		op_next = op_reg;
		cnt_next = cnt_reg;
		step_next = step_reg;
		addr_next = addr_reg;
		dq_next = dq_reg;
		dq_oe_n_next = dq_oe_n_reg;
		ce_n_next = ce_n_reg;
		we_n_next = we_n_reg;
		oe_n_next = oe_n_reg;
		status_next = status_reg;
		rdata_next = rdata_reg;
		done_next = 1'b0;
		refused_next = 1'b0;
		err_pend_next = err_pend_reg;
		unique case (state_reg)
			S_IDLE:
			begin
				if (i_req && req_refuse)
					refused_next = 1'b1;
				else if (i_req)
				begin
					op_next = fcss_op_t'(i_op);
					addr_next = i_addr;
					step_next = 1'b0;
					state_next = S_SETUP;
				end
			end
			S_SETUP:
			begin
				// Address settles one cycle before the strobe; data and chip enable drive with it
				ce_n_next = 1'b0;
				dq_oe_n_next = 1'b0;
				dq_next = {8'h00, step_reg ? second_code : first_code};
				we_n_next = 1'b0;
				cnt_next = WE_LOW_CYC;
				state_next = S_WE_LOW;
			end
			S_WE_LOW:
			begin
				cnt_next = cnt_reg - 8'h01;
				if (cnt_reg == 8'h01)
				begin
					we_n_next = 1'b1;
					cnt_next = WE_HIGH_CYC;
					state_next = S_WE_HIGH;
				end
			end
			S_WE_HIGH:
			begin
				// Data held through the recovery time, then released
				cnt_next = cnt_reg - 8'h01;
				if (cnt_reg == 8'h01)
				begin
					dq_oe_n_next = 1'b1;
					ce_n_next = 1'b1;
					if (!step_reg && has_second)
					begin
						step_next = 1'b1;
						state_next = S_SETUP;
					end
					else if (end_kind == END_NONE)
						state_next = S_DONE;
					else
					begin
						ce_n_next = 1'b0;
						oe_n_next = 1'b0;
						cnt_next = ACCESS_CYC + SYNC_SETTLE_CYC;
						state_next = S_RD_ACCESS;
					end
				end
			end
			S_RD_ACCESS:
			begin
				cnt_next = cnt_reg - 8'h01;
				if (cnt_reg == 8'h01)
					state_next = S_RD_SAMPLE;
			end
			S_RD_SAMPLE:
			begin
				// Wait for the synchronised data to agree before use
				if (dq_stable)
				begin
					rdata_next = dq_sync;
					status_next = sampled_status;
					oe_n_next = 1'b1;
					ce_n_next = 1'b1;
					cnt_next = READ_GAP_CYC;
					state_next = poll_again ? S_RD_GAP : S_DONE;
				end
			end
			S_RD_GAP:
			begin
				// Toggling the enables lets the device refresh its status
				cnt_next = cnt_reg - 8'h01;
				if (cnt_reg == 8'h01)
				begin
					ce_n_next = 1'b0;
					oe_n_next = 1'b0;
					cnt_next = ACCESS_CYC + SYNC_SETTLE_CYC;
					state_next = S_RD_ACCESS;
				end
			end
			S_DONE:
			begin
				done_next = 1'b1;
				if (op_reg == OP_CLEAR_STATUS)
					err_pend_next = 1'b0;
				else if (status_read && |(status_reg & SR_ERROR_MASK))
					err_pend_next = 1'b1;
				state_next = S_IDLE;
			end
		endcase
	end

	// Control state
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			state_reg <= S_IDLE;
			op_reg <= OP_READ_ARRAY;
			cnt_reg <= 8'h00;
			step_reg <= 1'b0;
			err_pend_reg <= 1'b0;
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
			rp_n_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			op_reg <= op_next;
			cnt_reg <= cnt_next;
			step_reg <= step_next;
			err_pend_reg <= err_pend_next;
			done_reg <= done_next;
			refused_reg <= refused_next;
			rp_n_reg <= 1'b1;
		end
	end

	// Pin and result registers
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			addr_reg <= ADDR_RESET;
			dq_reg <= DQ_RESET;
			dq_oe_n_reg <= 1'b1;
			ce_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			status_reg <= STATUS_RESET;
			rdata_reg <= DQ_RESET;
		end
		else
		begin
			addr_reg <= addr_next;
			dq_reg <= dq_next;
			dq_oe_n_reg <= dq_oe_n_next;
			ce_n_reg <= ce_n_next;
			we_n_reg <= we_n_next;
			oe_n_reg <= oe_n_next;
			status_reg <= status_next;
			rdata_reg <= rdata_next;
		end
	end

	assign o_req_ready = (state_reg == S_IDLE);
	assign o_done = done_reg;
	assign o_refused = refused_reg;
	assign o_status = status_reg;
	assign o_rdata = rdata_reg;
	assign o_error_pending = err_pend_reg;
	assign o_device_ready = rb_sync[0];
	assign o_reset_powerdown_n = rp_n_reg;
	assign o_ce_n = ce_n_reg;
	assign o_we_n = we_n_reg;
	assign o_oe_n = oe_n_reg;
	assign o_addr = addr_reg;
	assign o_dq = dq_reg;
	assign o_dq_oe_n = dq_oe_n_reg;

	// Last code written, for checking setup/confirm pairing
	logic [7:0] last_code_reg;
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			last_code_reg <= 8'h00;
		else if (state_reg == S_WE_HIGH && cnt_reg == 8'h01)
			last_code_reg <= dq_reg[7:0];
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	sequence wr_end_s;
		$rose(o_we_n);
	endsequence
	sequence rd_start_s;
		##[1:40] $fell(o_oe_n);
	endsequence

	status_mask_a: assert property (o_status[0] == 1'b0)
		else $error("reserved status bit reported");
	erase_confirm_a: assert property (wr_end_s and last_code_reg == CMD_ERASE_SETUP
		|-> o_dq[7:0] == CMD_CONFIRM && o_addr == $past(o_addr))
		else $error("block erase setup not followed by confirm");
	chip_confirm_a: assert property (wr_end_s and last_code_reg == CMD_CHIP_SETUP
		|-> o_dq[7:0] == CMD_CONFIRM)
		else $error("chip erase setup not followed by confirm");
	lock_confirm_a: assert property (wr_end_s and last_code_reg == CMD_LOCK_SETUP
		|-> o_dq[7:0] == CMD_LOCK_BLOCK || o_dq[7:0] == CMD_LOCK_PERM)
		else $error("lock setup not followed by lock confirm");
	retry_blocked_a: assert property (wr_end_s and o_dq[7:0] == CMD_ERASE_SETUP
		|-> !o_error_pending)
		else $error("erase issued with error pending");
	poll_ready_a: assert property (o_done && status_read && op_reg != OP_READ_STATUS
		|-> o_status[SR_READY_BIT])
		else $error("operation finished before device ready");
	array_read_a: assert property (wr_end_s and o_dq[7:0] == CMD_READ_ARRAY
		|-> rd_start_s)
		else $error("no array read after read-array write");
	suspend_poll_a: assert property (wr_end_s and o_dq[7:0] == CMD_SUSPEND
		|-> rd_start_s)
		else $error("suspend not followed by status poll");
	write_drive_a: assert property (!o_we_n |-> !o_dq_oe_n && !o_ce_n && o_oe_n
		##1 (!o_we_n || o_dq_oe_n == 1'b0))
		else $error("data bus not driven around write strobe");

endmodule : fcss_host

`default_nettype wire

// ==== tb/fcss_flash_model.sv ====
// Purpose: Behavioural flash device facing the host sequencer.
// Assumes: Commands latch as write enable rises under chip enable.
// Notes: Busy time counts bench ticks; reserved status bit reads 1.
`timescale 1ns/1ps
`default_nettype none

module fcss_flash_model #(
	parameter int BUSY_CYC = 80,
	parameter logic [7:0] CLR_CODE = 8'h50
) (
	input wire logic i_tick,
	input wire logic i_rp_n,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [19:0] i_addr,
	input wire logic [15:0] i_dq,
	input wire logic i_dq_oe_n,
	input wire logic [15:0] i_lock_mask,
	input wire logic i_perm_lock,
	input wire logic i_wp_n,
	input wire logic i_supply_ok,
	input wire logic i_write_start,
	output logic [15:0] o_dq,
	output logic o_ready_busy_n,
	output logic [15:0] o_cmds
);
	logic [7:0] flags, setup, cmd;
	logic we_q, stat_mode, susp, prot;
	int busy, err;
	wire logic [7:0] sr = {busy == 0 || susp, flags[6:1], 1'b1};
	wire logic [15:0] rd = stat_mode ? {8'h00, sr} : i_addr[15:0] ^ 16'h5A3C;

	initial o_dq = 16'h0000;

	// Decoder and busy timer; the reset pin clears both
	always @(posedge i_tick)
	begin
		if (!i_rp_n)
		begin
			flags = 8'h00;
			setup = 8'h00;
			stat_mode = 1'b0;
			susp = 1'b0;
			busy = 0;
		end
		else
		begin
			if (busy > 0 && !susp)
				busy--;
			if (i_write_start)
				busy = BUSY_CYC;
			if (!we_q && i_we_n && !i_ce_n && !i_dq_oe_n)
			begin
				cmd = i_dq[7:0];
				o_cmds = {o_cmds[7:0], cmd};
				stat_mode = cmd != 8'hFF;
				if (setup != 8'h00)
				begin
					err = (setup == 8'h60) ? 4 : 5;
					if (setup == 8'h20)
						prot = i_lock_mask[i_addr[19:16]] | i_perm_lock;
					else if (setup == 8'h30)
						prot = &i_lock_mask;
					else
						prot = i_perm_lock && cmd == 8'h01;
					if (setup == 8'h60 ? cmd != 8'h01 && cmd != 8'hF1 : cmd != 8'hD0)
						flags[5:4] = 2'b11;
					else if (!i_supply_ok)
						flags = flags | 8'h08 | (8'h01 << err);
					else if (prot || !i_wp_n)
						flags = flags | 8'h02 | (8'h01 << err);
					else
						busy = BUSY_CYC;
					setup = 8'h00;
				end
				else if (cmd == 8'h20 || cmd == 8'h30 || cmd == 8'h60)
					setup = cmd;
				else if (cmd == CLR_CODE)
					flags = flags & 8'h04;
				else if (cmd == 8'hB0 && busy > 0)
					{susp, flags[2]} = 2'b11;
				else if (cmd == 8'hD0)
					{susp, flags[2]} = 2'b00;
			end
		end
		we_q = i_we_n;
		// A released bus toggles so a stale value never passes
		o_dq = (!i_ce_n && !i_oe_n && i_rp_n) ? rd : ~o_dq;
		o_ready_busy_n = busy == 0 || susp;
	end

endmodule : fcss_flash_model
`default_nettype wire

// ==== tb/fcss_host_tb_top.sv ====
// Purpose: Self-checking bench for the flash host sequencer.
// Assumes: Flash model keeps each accepted erase, lock or write busy for 80 cycles.
// Notes: Error table, suspend, reset, then random reads.
`timescale 1ns/1ps
`default_nettype none

module fcss_host_tb_top
	import fcss_pkg::*;
	;
	logic i_mclk, i_rst, i_req, i_ready_busy_n, o_req_ready, o_done, o_refused;
	logic o_error_pending, o_device_ready, o_rp_n, o_ce_n, o_we_n, o_oe_n, o_dq_oe_n;
	logic wp_n, perm, sup_ok, wr_start, saw_busy;
	logic [3:0] i_op;
	logic [ADDR_W-1:0] i_addr, o_addr, a;
	logic [DQ_W-1:0] i_dq, o_dq, o_rdata, cmds, locks;
	logic [7:0] o_status;
	logic [31:0] seed;
	int n_fail, n_compared, res;
	// Op, {supply ok, write enable, permanent lock, all locked}, status, codes
	logic [3:0] e_op [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h2, 4'h1, 4'h0};
	logic [3:0] e_cfg [8] = '{4'h4, 4'hD, 4'hE, 4'h8, 4'hD, 4'hC, 4'hC, 4'hC};
	logic [7:0] e_sr [8] = '{8'hA8, 8'hA2, 8'h92, 8'h92, 8'hA2, 8'h80, 8'h80, 8'h80};
	logic [15:0] e_cmd [8] = '{16'h20D0, 16'h30D0, 16'h6001, 16'h60F1, 16'h20D0, 16'h6001,
		16'h30D0, 16'h20D0};

	fcss_host uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
		.o_req_ready(o_req_ready), .o_done(o_done), .o_refused(o_refused), .o_status(o_status),
		.o_rdata(o_rdata), .o_error_pending(o_error_pending), .o_device_ready(o_device_ready),
		.o_reset_powerdown_n(o_rp_n), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
		.o_addr(o_addr), .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
		.i_ready_busy_n(i_ready_busy_n));
	fcss_flash_model dev (.i_tick(i_mclk), .i_rp_n(o_rp_n), .i_ce_n(o_ce_n), .i_we_n(o_we_n),
		.i_oe_n(o_oe_n), .i_addr(o_addr), .i_dq(o_dq), .i_dq_oe_n(o_dq_oe_n),
		.i_lock_mask(locks), .i_perm_lock(perm), .i_wp_n(wp_n), .i_supply_ok(sup_ok),
		.i_write_start(wr_start), .o_dq(i_dq), .o_ready_busy_n(i_ready_busy_n), .o_cmds(cmds));

	// 100 MHz clock
	initial
	begin
		i_mclk = 1'b0;
		forever
			#5 i_mclk = ~i_mclk;
	end

	// Latch any busy phase on the synchronised ready pin
	always @(posedge i_mclk)
		if (o_device_ready === 1'b0)
			saw_busy <= 1'b1;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic tally_and_finish;
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// One request, then a bounded wait for done (1) or refused (2)
	task automatic run(input logic [3:0] op, input logic [19:0] addr, input logic [15:0] want);
		res = 0;
		saw_busy <= 1'b0;
		@(posedge i_mclk);
		i_req <= 1'b1;
		i_op <= op;
		i_addr <= addr;
		@(posedge i_mclk);
		i_req <= 1'b0;
		for (int k = 0; k < 20000 && res == 0; k++)
		begin
			#1;
			res = o_done === 1'b1 ? 1 : o_refused === 1'b1 ? 2 : 0;
			if (res == 0)
				@(posedge i_mclk);
		end
		if (res == 0)
		begin
			n_fail++;
			$display("unexpected at %0t: request never answered", $time);
			tally_and_finish();
		end
		else
			chk(16'(res), want);
	endtask : run

	// Reset pulse of three cycles from an edge, then four settle edges;
	// the ready synchroniser clears low, so it needs the flush to show ready
	task automatic do_reset;
		@(posedge i_mclk);
		i_rst <= 1'b1;
		repeat (3)
			@(posedge i_mclk);
		i_rst <= 1'b0;
		repeat (4)
			@(posedge i_mclk);
		#1;
	endtask : do_reset

	initial
	begin
		{i_rst, i_req, i_op, i_addr} = {1'b1, 1'b0, 4'h0, 20'h00000};
		{locks, perm, wp_n, sup_ok, wr_start, saw_busy} = {16'h0000, 5'b01100};
		{n_fail, n_compared, seed} = {32'h0, 32'h0, 32'h00009E09};
		do_reset();
		chk(16'({o_rp_n, o_ce_n, o_we_n, o_oe_n, o_dq_oe_n, o_status}), 16'h1F00);
		chk(16'({o_req_ready, o_done, o_refused, o_error_pending, o_device_ready}), 16'h0011);
		chk(o_dq | o_addr[15:0] | o_rdata, 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			a = seed[19:0];
			{sup_ok, wp_n, perm} = e_cfg[i][3:1];
			locks = {16{e_cfg[i][0]}};
			run(e_op[i], a, 16'h0001);
			chk(16'(o_status), 16'(e_sr[i]));
			chk(cmds, e_cmd[i]);
			chk(16'(saw_busy), 16'(e_sr[i] == 8'h80));
			chk(16'(o_error_pending), 16'(e_sr[i] != 8'h80));
			if (e_sr[i] != 8'h80)
			begin
				run(4'h0, a, 16'h0002);
				run(4'h6, a, 16'h0001);
				chk(16'(o_status), 16'(e_sr[i]));
				run(4'h7, a, 16'h0001);
				chk(16'(o_error_pending), 16'h0000);
			end
		end
		// Suspend a write in flight, read around it, then resume
		@(posedge i_mclk);
		wr_start <= 1'b1;
		@(posedge i_mclk);
		wr_start <= 1'b0;
		run(4'h4, a, 16'h0001);
		chk(16'(o_status), 16'h0084);
		run(4'h8, a, 16'h0001);
		chk(o_rdata, a[15:0] ^ 16'h5A3C);
		run(4'h5, a, 16'h0001);
		run(4'h6, a, 16'h0001);
		chk(16'(o_status), 16'h0000);
		for (int k = 0; k < 200 && o_device_ready !== 1'b1; k++)
			@(posedge i_mclk);
		chk(16'(o_device_ready), 16'h0001);
		run(4'h6, a, 16'h0001);
		chk(16'(o_status), 16'h0080);
		// A reset with an error pending clears host and device status
		sup_ok <= 1'b0;
		run(4'h0, a, 16'h0001);
		sup_ok <= 1'b1;
		do_reset();
		chk(16'(o_error_pending), 16'h0000);
		run(4'h6, a, 16'h0001);
		chk(16'(o_status), 16'h0080);
		// Random array reads mixed with illegal operation codes
		for (int i = 0; i < 24; i++)
		begin
			seed = xs(seed);
			a = seed[19:0];
			if (seed[21:20] == 2'b11)
				run(4'(9 + seed[24:22] % 7), a, 16'h0002);
			else
			begin
				run(4'h8, a, 16'h0001);
				chk(o_rdata, a[15:0] ^ 16'h5A3C);
				chk(o_addr[15:0], a[15:0]);
			end
		end
		tally_and_finish();
	end

endmodule : fcss_host_tb_top
`default_nettype wire
